// ===== design/dfsc_bank.sv
`timescale 1ns/1ps
// Two-entry store: one fault status copy per security state
module dfsc_bank (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic wr_sel_in,
	input wire logic [31:0] wr_data_in,
	input wire logic rd_sel_in,
	output logic [31:0] rd_data_out
);

	logic [31:0] copy_ff [2];

	// ****************************************
	// Storage
	// ****************************************
	// Only documented fields are kept, reserved bits never hold ones
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			copy_ff[0] <= dfsc_pkg::STATUS_RESET;
			copy_ff[1] <= dfsc_pkg::STATUS_RESET;
		end else if (wr_en_in) begin
			copy_ff[wr_sel_in] <= wr_data_in & dfsc_pkg::WRITABLE_MASK;
		end
	end

	// Registered read port, one cycle after the select
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= dfsc_pkg::STATUS_RESET;
		end else begin
			rd_data_out <= copy_ff[rd_sel_in];
		end
	end

endmodule

// ===== design/dfsc_encoder.sv
`timescale 1ns/1ps
// Priority encoder from fault conditions to a five-bit status code
module dfsc_encoder (
	input wire logic [14:0] cond_in,
	output logic valid_out,
	output logic [4:0] code_out,
	output logic external_out
);

	// ****************************************
	// Code table
	// ****************************************
	function automatic logic [4:0] code_of(input int idx);
		logic [4:0] c;
		c = dfsc_pkg::FS_DEBUG;
		unique case (idx)
			dfsc_pkg::C_ALIGN: c = dfsc_pkg::FS_ALIGN;
			dfsc_pkg::C_ICACHE: c = dfsc_pkg::FS_ICACHE_MAINT;
			dfsc_pkg::C_WALK1: c = dfsc_pkg::FS_WALK1_EXT;
			dfsc_pkg::C_WALK2: c = dfsc_pkg::FS_WALK2_EXT;
			dfsc_pkg::C_XSECT: c = dfsc_pkg::FS_XLAT_SECT;
			dfsc_pkg::C_XPAGE: c = dfsc_pkg::FS_XLAT_PAGE;
			dfsc_pkg::C_AFSECT: c = dfsc_pkg::FS_AF_SECT;
			dfsc_pkg::C_AFPAGE: c = dfsc_pkg::FS_AF_PAGE;
			dfsc_pkg::C_DSECT: c = dfsc_pkg::FS_DOM_SECT;
			dfsc_pkg::C_DPAGE: c = dfsc_pkg::FS_DOM_PAGE;
			dfsc_pkg::C_PSECT: c = dfsc_pkg::FS_PERM_SECT;
			dfsc_pkg::C_PPAGE: c = dfsc_pkg::FS_PERM_PAGE;
			dfsc_pkg::C_SEXT: c = dfsc_pkg::FS_SYNC_EXT;
			dfsc_pkg::C_AEXT: c = dfsc_pkg::FS_ASYNC_EXT;
			default: c = dfsc_pkg::FS_DEBUG;
		endcase
		return c;
	endfunction

	// ****************************************
	// Priority pick, lowest index wins
	// ****************************************
	// Scan downward so the highest-priority set bit is the last assigned
	always_comb begin
		valid_out = 1'b0;
		code_out = dfsc_pkg::FS_DEBUG;
		external_out = 1'b0;
		for (int i = dfsc_pkg::NUM_COND - 1; i >= 0; i--) begin
			if (cond_in[i]) begin
				valid_out = 1'b1;
				code_out = code_of(i);
				external_out = (i == dfsc_pkg::C_WALK1) || (i == dfsc_pkg::C_WALK2) ||
					(i == dfsc_pkg::C_SEXT) || (i == dfsc_pkg::C_AEXT);
			end
		end
	end

endmodule

// ===== design/dfsc_pkg.sv
package dfsc_pkg;

	// ****************************************
	// Register layout
	// ****************************************
	localparam int QUAL_BIT = 12;
	localparam int WRITE_NOT_READ_BIT = 11;
	localparam int CODE_MSB_BIT = 10;
	localparam int DOM_LSB = 4;
	localparam int DOM_MSB = 7;
	localparam int CODE_LO_MSB = 3;
	localparam logic [31:0] WRITABLE_MASK = 32'h00001CFF;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	localparam logic [3:0] CRN_FAULT_STATUS = 4'h5;
	localparam logic [3:0] CRM_FAULT_STATUS = 4'h0;
	localparam logic [2:0] OP1_FAULT_STATUS = 3'h0;
	localparam logic [2:0] OP2_FAULT_STATUS = 3'h0;

	// ****************************************
	// Fault status codes (bit 4 = status_code_msb, x held as 0)
	// ****************************************
	localparam logic [4:0] FS_ALIGN = 5'h01;
	localparam logic [4:0] FS_ICACHE_MAINT = 5'h04;
	localparam logic [4:0] FS_WALK1_EXT = 5'h0C;
	localparam logic [4:0] FS_WALK2_EXT = 5'h0E;
	localparam logic [4:0] FS_XLAT_SECT = 5'h05;
	localparam logic [4:0] FS_XLAT_PAGE = 5'h07;
	localparam logic [4:0] FS_AF_SECT = 5'h03;
	localparam logic [4:0] FS_AF_PAGE = 5'h06;
	localparam logic [4:0] FS_DOM_SECT = 5'h09;
	localparam logic [4:0] FS_DOM_PAGE = 5'h0B;
	localparam logic [4:0] FS_PERM_SECT = 5'h0D;
	localparam logic [4:0] FS_PERM_PAGE = 5'h0F;
	localparam logic [4:0] FS_SYNC_EXT = 5'h08;
	localparam logic [4:0] FS_ASYNC_EXT = 5'h16;
	localparam logic [4:0] FS_DEBUG = 5'h02;

	// Fault condition vector bit positions, highest priority first
	localparam int NUM_COND = 15;
	localparam int C_ALIGN = 0;
	localparam int C_ICACHE = 1;
	localparam int C_WALK1 = 2;
	localparam int C_WALK2 = 3;
	localparam int C_XSECT = 4;
	localparam int C_XPAGE = 5;
	localparam int C_AFSECT = 6;
	localparam int C_AFPAGE = 7;
	localparam int C_DSECT = 8;
	localparam int C_DPAGE = 9;
	localparam int C_PSECT = 10;
	localparam int C_PPAGE = 11;
	localparam int C_SEXT = 12;
	localparam int C_AEXT = 13;
	localparam int C_DEBUG = 14;

	// Bus response kinds
	localparam logic BUS_DECERR = 1'b0;
	localparam logic BUS_SLVERR = 1'b1;

endpackage

// ===== design/dfsc_top.sv
`timescale 1ns/1ps
// Behaviour
// - External abort qualifier bit 12 is 0 for DECERR, 1 for SLVERR.
// - Qualifier bit stays zero for every non-external abort.
// - Bit 11 records access direction, 0 read, 1 write.
// - Aborted coprocessor operations force bit 11 to 1.
// - Code bit 4 goes in bit 10, low four bits in 3:0.
// - Bits 7:4 hold the domain number of the faulting access.
// - Only the highest-priority condition of one access is reported.
// - Alignment is 000001 first, cache maintenance 000100 second.
// - Walk external aborts are x01100 first level, x01110 second level.
// - Translation faults: section 000101, page 000111.
// - Access flag faults: section 000011, page 000110.
// - Domain faults use 001001, with a page variant beside it.
// - Permission faults use 001101 and 001111, below domain faults.
// - Non-walk synchronous external abort is x01000.
// - Asynchronous external abort is x10110.
// - Debug event is 000010, lowest priority.
// - Reserved status codes are never produced.
// - Qualifier bit is zero after reset.
// - Coprocessor read of c5 with opcode2 zero returns the word.
// - Coprocessor write of the same register loads the word.
// - Each copy holds the most recent data fault or software write of its security state; a fault drops any software write of the same cycle.
// - Privileged access only, one copy per security state.
module dfsc_top (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic ABORT_VALID_IN,
	input wire logic [14:0] ABORT_COND_IN,
	input wire logic ABORT_WRITE_IN,
	input wire logic ABORT_COPROC_IN,
	input wire logic ABORT_BUS_SLVERR_IN,
	input wire logic [3:0] ABORT_DOMAIN_IN,
	input wire logic ABORT_SECURE_IN,
	input wire logic CP_VALID_IN,
	input wire logic CP_WRITE_IN,
	input wire logic [2:0] CP_OP1_IN,
	input wire logic [3:0] CP_CRN_IN,
	input wire logic [3:0] CP_CRM_IN,
	input wire logic [2:0] CP_OP2_IN,
	input wire logic [31:0] CP_WDATA_IN,
	input wire logic CP_PRIV_IN,
	input wire logic CP_SECURE_IN,
	output logic CP_HIT_OUT,
	output logic CP_UNDEF_OUT,
	output logic CP_RVALID_OUT,
	output logic [31:0] CP_RDATA_OUT,
	output logic FAULT_RECORDED_OUT
);

	// ****************************************
	// Fault word assembly
	// ****************************************
	logic enc_valid;
	logic [4:0] enc_code;
	logic enc_external;
	logic [31:0] fault_word;
	logic fault_take;

	dfsc_encoder u_encoder (
		.cond_in(ABORT_COND_IN),
		.valid_out(enc_valid),
		.code_out(enc_code),
		.external_out(enc_external)
	);

	// A valid strobe with no condition bit set records nothing
	assign fault_take = ABORT_VALID_IN && enc_valid;

	// Word fields from the chosen code and the access attributes
	always_comb begin
		fault_word = 32'h00000000;
		fault_word[dfsc_pkg::QUAL_BIT] = enc_external && ABORT_BUS_SLVERR_IN;
		fault_word[dfsc_pkg::WRITE_NOT_READ_BIT] = ABORT_WRITE_IN || ABORT_COPROC_IN;
		fault_word[dfsc_pkg::CODE_MSB_BIT] = enc_code[4];
		fault_word[dfsc_pkg::CODE_LO_MSB:0] = enc_code[3:0];
		fault_word[dfsc_pkg::DOM_MSB:dfsc_pkg::DOM_LSB] = ABORT_DOMAIN_IN;
	end

	// ****************************************
	// Coprocessor access decode
	// ****************************************
	logic cp_match;
	logic cp_write_ok;
	logic cp_read_ok;
	logic rd_pending_ff;

	assign cp_match = CP_VALID_IN && (CP_CRN_IN == dfsc_pkg::CRN_FAULT_STATUS) &&
		(CP_CRM_IN == dfsc_pkg::CRM_FAULT_STATUS) && (CP_OP1_IN == dfsc_pkg::OP1_FAULT_STATUS) &&
		(CP_OP2_IN == dfsc_pkg::OP2_FAULT_STATUS);
	// User mode access is refused and left to the undefined trap
	assign CP_HIT_OUT = cp_match;
	assign CP_UNDEF_OUT = cp_match && !CP_PRIV_IN;
	assign cp_write_ok = cp_match && CP_PRIV_IN && CP_WRITE_IN;
	assign cp_read_ok = cp_match && CP_PRIV_IN && !CP_WRITE_IN;

	// ****************************************
	// Banked storage
	// ****************************************
	logic bank_wr_en;
	logic bank_wr_sel;
	logic [31:0] bank_wr_data;
	logic [31:0] bank_rd_data;

	// A fault beats a software write in the same cycle so it is not lost
	always_comb begin
		bank_wr_en = fault_take || cp_write_ok;
		bank_wr_sel = CP_SECURE_IN;
		bank_wr_data = CP_WDATA_IN;
		if (fault_take) begin
			bank_wr_sel = ABORT_SECURE_IN;
			bank_wr_data = fault_word;
		end
	end

	dfsc_bank u_bank (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.wr_en_in(bank_wr_en),
		.wr_sel_in(bank_wr_sel),
		.wr_data_in(bank_wr_data),
		.rd_sel_in(CP_SECURE_IN),
		.rd_data_out(bank_rd_data)
	);

	// ****************************************
	// Read answer
	// ****************************************
	// Read data comes one cycle after the request, from the bank register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rd_pending_ff <= 1'b0;
		end else begin
			rd_pending_ff <= cp_read_ok;
		end
	end

	assign CP_RVALID_OUT = rd_pending_ff;
	assign CP_RDATA_OUT = rd_pending_ff ? bank_rd_data : 32'h00000000;

	// Recording pulse, one cycle after the captured fault
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			FAULT_RECORDED_OUT <= 1'b0;
		end else begin
			FAULT_RECORDED_OUT <= fault_take;
		end
	end

endmodule

// ===== verification/dfsc_abort_model.sv
`timescale 1ns/1ps
// ****
// Load/store abort source
// ****
module dfsc_abort_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire logic [22:0] pkt_in,
	output logic valid_out,
	output logic [22:0] pkt_out
);
	// One-cycle abort pulse; idle fields toggle so stale values are never trusted
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			valid_out <= 1'b0;
			pkt_out <= 23'h0;
		end else begin
			valid_out <= req_in;
			pkt_out <= req_in ? pkt_in : ~pkt_out;
		end
	end
endmodule

// ===== verification/dfsc_checker.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module dfsc_checker (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic ABORT_VALID_IN,
	input wire logic [14:0] ABORT_COND_IN,
	input wire logic CP_VALID_IN,
	input wire logic CP_WRITE_IN,
	input wire logic [2:0] CP_OP1_IN,
	input wire logic [3:0] CP_CRN_IN,
	input wire logic [3:0] CP_CRM_IN,
	input wire logic [2:0] CP_OP2_IN,
	input wire logic CP_PRIV_IN,
	input wire logic CP_HIT_OUT,
	input wire logic CP_UNDEF_OUT,
	input wire logic CP_RVALID_OUT,
	input wire logic [31:0] CP_RDATA_OUT,
	input wire logic FAULT_RECORDED_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// Decode and accepted read, shared by several checks
	wire dec = CP_OP1_IN == 3'h0 && CP_CRN_IN == 4'h5 && CP_CRM_IN == 4'h0 && CP_OP2_IN == 3'h0;
	wire rd = CP_VALID_IN && dec && CP_PRIV_IN && !CP_WRITE_IN;
	wire flt = ABORT_VALID_IN && ABORT_COND_IN != 15'h0;
	a_hit_decode: assert property (CP_VALID_IN |-> CP_HIT_OUT == dec)
		else $error("hit does not match decode");
	a_undef_priv: assert property (CP_VALID_IN |-> CP_UNDEF_OUT == (dec && !CP_PRIV_IN))
		else $error("undef wrong");
	a_read_answer: assert property (rd |=> CP_RVALID_OUT)
		else $error("read not answered");
	a_rvalid_cause: assert property (CP_RVALID_OUT |-> $past(rd))
		else $error("read answer without request");
	a_unpriv_quiet: assert property (CP_VALID_IN && !CP_PRIV_IN |=> !CP_RVALID_OUT)
		else $error("unprivileged read answered");
	a_data_idle: assert property (!CP_RVALID_OUT |-> CP_RDATA_OUT == 32'h0)
		else $error("read data not idle");
	a_reserved_zero: assert property (CP_RVALID_OUT |-> (CP_RDATA_OUT & 32'hFFFFE300) == 32'h0)
		else $error("reserved bits set");
	a_fault_pulse: assert property (flt |=> FAULT_RECORDED_OUT)
		else $error("fault not recorded");
	a_fault_cause: assert property (FAULT_RECORDED_OUT |-> $past(flt))
		else $error("record without fault");
endmodule

bind dfsc_top dfsc_checker chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.ABORT_VALID_IN(ABORT_VALID_IN), .ABORT_COND_IN(ABORT_COND_IN), .CP_VALID_IN(CP_VALID_IN),
	.CP_WRITE_IN(CP_WRITE_IN), .CP_OP1_IN(CP_OP1_IN), .CP_CRN_IN(CP_CRN_IN),
	.CP_CRM_IN(CP_CRM_IN), .CP_OP2_IN(CP_OP2_IN), .CP_PRIV_IN(CP_PRIV_IN),
	.CP_HIT_OUT(CP_HIT_OUT), .CP_UNDEF_OUT(CP_UNDEF_OUT), .CP_RVALID_OUT(CP_RVALID_OUT),
	.CP_RDATA_OUT(CP_RDATA_OUT), .FAULT_RECORDED_OUT(FAULT_RECORDED_OUT));

// ===== verification/tb_top.sv
`timescale 1ns/1ps
// ****
// Fault status bench
// ****
module tb_top;
	logic clk, rst_n, cv, cw, cp, cs, req, av, rv, q;
	logic [2:0] op1, op2;
	logic [3:0] crn, crm;
	logic [31:0] wd, rd, e, d, m;
	logic [22:0] pkt, ap;
	logic [15:0] lf = 16'h003A;
	logic [15:0] r, n;
	logic [14:0] cond;
	logic [4:0] code;
	logic [31:0] expq [$];
	logic [4:0] codes [15] = '{5'h01, 5'h04, 5'h0C, 5'h0E, 5'h05, 5'h07, 5'h03, 5'h06, 5'h09,
		5'h0B, 5'h0D, 5'h0F, 5'h08, 5'h16, 5'h02};
	int bad_count = 0;
	int compares = 0;
	int i;
	dfsc_abort_model mdl_u (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .pkt_in(pkt),
		.valid_out(av), .pkt_out(ap));
	dfsc_top dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .ABORT_VALID_IN(av),
		.ABORT_COND_IN(ap[22:8]), .ABORT_WRITE_IN(ap[7]), .ABORT_COPROC_IN(ap[6]),
		.ABORT_BUS_SLVERR_IN(ap[5]), .ABORT_DOMAIN_IN(ap[4:1]), .ABORT_SECURE_IN(ap[0]),
		.CP_VALID_IN(cv), .CP_WRITE_IN(cw), .CP_OP1_IN(op1), .CP_CRN_IN(crn),
		.CP_CRM_IN(crm), .CP_OP2_IN(op2), .CP_WDATA_IN(wd), .CP_PRIV_IN(cp),
		.CP_SECURE_IN(cs), .CP_HIT_OUT(), .CP_UNDEF_OUT(), .CP_RVALID_OUT(rv),
		.CP_RDATA_OUT(rd), .FAULT_RECORDED_OUT());
	// Pseudo-random source
	function logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude();
		if (expq.size() != 0) bad_count++;
		$display("counts: compares=%0d bad=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One coprocessor access; expectation noted before the request goes out
	task acc(input logic w, s, p, input logic [2:0] o2, input logic [31:0] dd, ex, input logic c);
		if (c) expq.push_back(ex);
		@(posedge clk);
		cv <= 1'b1;
		cw <= w;
		cs <= s;
		cp <= p;
		op2 <= o2;
		wd <= dd;
		@(posedge clk);
		cv <= 1'b0;
	endtask
	// Abort through the model: one edge to launch, one to present, one to capture
	task flt(input logic [22:0] p);
		@(posedge clk);
		req <= 1'b1;
		pkt <= p;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Read answers checked after the edge settles; a stray answer fails
	always @(posedge clk) begin
		#1;
		if (rv === 1'b1) begin
			if (expq.size() == 0) cmp(rd, 32'hX);
			else cmp(rd, expq.pop_front());
		end
	end
	initial begin
		#20000;
		bad_count++;
		conclude();
	end
	initial begin
		{rst_n, cv, cw, cp, cs, req, op1, op2, crm, wd, pkt} = '0;
		crn = 4'h5;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		acc(1'b0, 1'b0, 1'b1, 3'h0, 32'h0, 32'h0, 1'b1);
		acc(1'b0, 1'b1, 1'b1, 3'h0, 32'h0, 32'h0, 1'b1);
		$display("test reset done");
		// Each code with random lower-priority noise above it
		for (i = 0; i < 15; i++) begin
			r = rnd();
			n = rnd();
			cond = (15'h1 << i) | (15'(n) << (i + 1));
			code = codes[i];
			q = (i == 2 || i == 3 || i == 12 || i == 13) ? r[6] : 1'b0;
			e = {19'h0, q, r[4] | r[5], code[4], 2'b00, r[3:0], code[3:0]};
			flt({cond, r[4], r[5], r[6], r[3:0], r[7]});
			acc(1'b0, r[7], 1'b1, 3'h0, 32'h0, e, 1'b1);
		end
		$display("test encode done");
		d = {rnd(), rnd()};
		m = (d & 32'h00001CFF) ^ 32'h000000F0;
		acc(1'b1, 1'b0, 1'b1, 3'h0, d, 32'h0, 1'b0);
		acc(1'b1, 1'b1, 1'b1, 3'h0, ~d, 32'h0, 1'b0);
		acc(1'b0, 1'b0, 1'b1, 3'h0, 32'h0, d & 32'h00001CFF, 1'b1);
		acc(1'b1, 1'b0, 1'b1, 3'h0, m, 32'h0, 1'b0);
		acc(1'b0, 1'b1, 1'b1, 3'h0, 32'h0, ~d & 32'h00001CFF, 1'b1);
		$display("test banks done");
		acc(1'b1, 1'b0, 1'b0, 3'h0, 32'h0000FFFF, 32'h0, 1'b0);
		acc(1'b0, 1'b0, 1'b0, 3'h0, 32'h0, 32'h0, 1'b0);
		acc(1'b1, 1'b0, 1'b1, 3'h1, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 1'b0, 1'b1, 3'h1, 32'h0, 32'h0, 1'b0);
		// Other register numbers must not reach the word either
		crn <= 4'h6;
		acc(1'b1, 1'b0, 1'b1, 3'h0, ~d, 32'h0, 1'b0);
		crn <= 4'h5;
		crm <= 4'h1;
		op1 <= 3'h1;
		acc(1'b1, 1'b0, 1'b1, 3'h0, ~d, 32'h0, 1'b0);
		crm <= 4'h0;
		op1 <= 3'h0;
		// Strobe with no condition bit must leave the word alone
		flt({15'h0, 8'hFE});
		acc(1'b0, 1'b0, 1'b1, 3'h0, 32'h0, m, 1'b1);
		$display("test refuse done");
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule
